// ---- verilog/clock_select_pkg.sv ----
// constants for the clock select and module stop block
`default_nettype none
package clock_select_pkg;

  // register byte addresses on the register bus
  localparam logic [23:0] CLOCK_FREQUENCY_SELECT_OFFS = 24'hff_fdc4;
  localparam logic [23:0] MODULE_STOP_CONTROL_A_OFFS  = 24'hff_fdc8;
  localparam logic [23:0] CLOCK_STATUS_OFFS           = 24'hff_fdcc;

  // field positions in clock_frequency_select
  localparam int SYS_CLK_SEL_LSB    = 8;
  localparam int PERIPH_CLK_SEL_LSB = 4;
  localparam int BUS_CLK_SEL_LSB    = 0;

  // field positions in module_stop_control_a
  localparam int ALL_CLOCK_STOP_ENABLE_BIT = 15;
  localparam int EXT_DMA_STOP_BIT          = 14;
  localparam int TIMER_UNIT_STOP_BIT       = 0;

  // field positions in the status register
  localparam int STAT_ALL_STOP_BIT = 0;
  localparam int STAT_RESERVED_BIT = 1;

  // select codes and the multipliers they give
  localparam logic [2:0] SEL_X4  = 3'h0;
  localparam logic [2:0] SEL_X2  = 3'h1;
  localparam logic [2:0] MULT_X4 = 3'h4;
  localparam logic [2:0] MULT_X2 = 3'h2;

  // reset values
  localparam logic [15:0] CLOCK_FREQUENCY_SELECT_RST = 16'h0010;
  localparam logic [15:0] MODULE_STOP_CONTROL_A_RST  = 16'h0000;

  // module stop bits that have a module behind them
  localparam logic [14:0] STOP_IMPLEMENTED_MASK = 15'h4001;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : clock_select_pkg
`default_nettype wire

// ---- verilog/clock_select_and_module_stop.sv ----
// clock select and module stop control with an AXI4-Lite register slave
//
// Summary of operation
// - System clock select is bits 10:8; code 000 gives input clock times four.
// - Peripheral clock select is bits 6:4; code 001 gives input clock times two.
// - Bus clock select is bits 2:0; code 000 gives input clock times four.
// - Writing 1 to a module stop bit stops that module; 0 restarts it.
// - Stop bit 14 is the external DMA; bit 0 the timer pulse unit.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module clock_select_and_module_stop #(
  parameter int ADDR_W = 24
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              cpu_sleep,
  output var  logic [2:0]        sys_clk_mult_q,
  output var  logic [2:0]        periph_clk_mult_q,
  output var  logic [2:0]        bus_clk_mult_q,
  output var  logic [14:0]       module_run_q,
  output var  logic              all_clock_stop_q
);

  logic [15:0]       clk_sel_q;
  logic [15:0]       mstop_q;
  logic              reserved_hit_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_held_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              w_held_q;
  logic              wr_do;
  logic              wr_cs;
  logic              wr_ms;
  logic              wr_st;
  logic              all_off;
  logic [2:0]        new_sys;
  logic [2:0]        new_per;
  logic [2:0]        new_bus;
  logic              sys_ok;
  logic              per_ok;
  logic              bus_ok;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
    else if (wr_do)
    begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
    else if (wr_do)
    begin
      w_held_q <= 1'b0;
    end
  end

  // one write under way at a time, so both readies are plain flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !(s_axi_awvalid && s_axi_awready) && !aw_held_q
                       && !s_axi_bvalid && !wr_do;
      s_axi_wready  <= !(s_axi_wvalid && s_axi_wready) && !w_held_q
                       && !s_axi_bvalid && !wr_do;
    end
  end

  assign wr_do = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_cs = awaddr_q[23:2] ==
                 clock_select_pkg::CLOCK_FREQUENCY_SELECT_OFFS[23:2];
  assign wr_ms = awaddr_q[23:2] ==
                 clock_select_pkg::MODULE_STOP_CONTROL_A_OFFS[23:2];
  assign wr_st = awaddr_q[23:2] ==
                 clock_select_pkg::CLOCK_STATUS_OFFS[23:2];

  // write response; unmapped addresses answer slave error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= clock_select_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_cs || wr_ms || wr_st) ? clock_select_pkg::RESP_OKAY
                                                : clock_select_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock select fields; a reserved code leaves the field as it was
  assign new_sys = wdata_q[clock_select_pkg::SYS_CLK_SEL_LSB +: 3];
  assign new_per = wdata_q[clock_select_pkg::PERIPH_CLK_SEL_LSB +: 3];
  assign new_bus = wdata_q[clock_select_pkg::BUS_CLK_SEL_LSB +: 3];
  assign sys_ok  = new_sys == clock_select_pkg::SEL_X4 ||
                   new_sys == clock_select_pkg::SEL_X2;
  assign per_ok  = new_per == clock_select_pkg::SEL_X4 ||
                   new_per == clock_select_pkg::SEL_X2;
  assign bus_ok  = new_bus == clock_select_pkg::SEL_X4 ||
                   new_bus == clock_select_pkg::SEL_X2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sel_q <= clock_select_pkg::CLOCK_FREQUENCY_SELECT_RST;
    end
    else if (wr_do && wr_cs)
    begin
      if (wstrb_q[1] && sys_ok)
      begin
        clk_sel_q[clock_select_pkg::SYS_CLK_SEL_LSB +: 3] <= new_sys;
      end
      if (wstrb_q[0] && per_ok)
      begin
        clk_sel_q[clock_select_pkg::PERIPH_CLK_SEL_LSB +: 3] <= new_per;
      end
      if (wstrb_q[0] && bus_ok)
      begin
        clk_sel_q[clock_select_pkg::BUS_CLK_SEL_LSB +: 3] <= new_bus;
      end
    end
  end

  // sticky reserved-code flag; write 1 clears, a new hit wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reserved_hit_q <= 1'b0;
    end
    else if (wr_do && wr_cs && ((wstrb_q[1] && !sys_ok) ||
             (wstrb_q[0] && !(per_ok && bus_ok))))
    begin
      reserved_hit_q <= 1'b1;
    end
    else if (wr_do && wr_st && wstrb_q[0] &&
             wdata_q[clock_select_pkg::STAT_RESERVED_BIT])
    begin
      reserved_hit_q <= 1'b0;
    end
  end

  // decoded multipliers for the clock generator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_clk_mult_q    <= clock_select_pkg::MULT_X4;
      periph_clk_mult_q <= clock_select_pkg::MULT_X2;
      bus_clk_mult_q    <= clock_select_pkg::MULT_X4;
    end
    else
    begin
      sys_clk_mult_q    <= clk_sel_q[clock_select_pkg::SYS_CLK_SEL_LSB +: 3]
        == clock_select_pkg::SEL_X4 ? clock_select_pkg::MULT_X4
                                    : clock_select_pkg::MULT_X2;
      periph_clk_mult_q <= clk_sel_q[clock_select_pkg::PERIPH_CLK_SEL_LSB +: 3]
        == clock_select_pkg::SEL_X4 ? clock_select_pkg::MULT_X4
                                    : clock_select_pkg::MULT_X2;
      bus_clk_mult_q    <= clk_sel_q[clock_select_pkg::BUS_CLK_SEL_LSB +: 3]
        == clock_select_pkg::SEL_X4 ? clock_select_pkg::MULT_X4
                                    : clock_select_pkg::MULT_X2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // module stop register, byte lanes honoured
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mstop_q <= clock_select_pkg::MODULE_STOP_CONTROL_A_RST;
    end
    else if (wr_do && wr_ms)
    begin
      if (wstrb_q[0])
      begin
        mstop_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1])
      begin
        mstop_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // only bits with a module behind them count toward all stopped
  assign all_off = &(mstop_q[14:0] | ~clock_select_pkg::STOP_IMPLEMENTED_MASK);

  // bus and port clocks halt only in sleep; waking clears the stop on the next edge, module runs return one edge later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      all_clock_stop_q <= 1'b0;
    end
    else
    begin
      all_clock_stop_q <= mstop_q[clock_select_pkg::ALL_CLOCK_STOP_ENABLE_BIT]
                          && cpu_sleep && all_off;
    end
  end

  // per-module clock enables
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi++)
    begin : g_run
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          module_run_q[gi] <= 1'b1;
        end
        else
        begin
          module_run_q[gi] <= !mstop_q[gi] && !all_clock_stop_q;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= clock_select_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= clock_select_pkg::RESP_OKAY;
      if (s_axi_araddr[23:2] ==
          clock_select_pkg::CLOCK_FREQUENCY_SELECT_OFFS[23:2])
      begin
        s_axi_rdata <= {16'h0000, clk_sel_q};
      end
      else if (s_axi_araddr[23:2] ==
               clock_select_pkg::MODULE_STOP_CONTROL_A_OFFS[23:2])
      begin
        s_axi_rdata <= {16'h0000, mstop_q};
      end
      else if (s_axi_araddr[23:2] ==
               clock_select_pkg::CLOCK_STATUS_OFFS[23:2])
      begin
        s_axi_rdata <= {30'h0000_0000, reserved_hit_q, all_clock_stop_q};
      end
      else
      begin
        s_axi_rdata <= '0;
        s_axi_rresp <= clock_select_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid)
    begin
      s_axi_rvalid  <= !s_axi_rready;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sys_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && wr_cs && wstrb_q[1] && new_sys == clock_select_pkg::SEL_X4
    |-> ##2 sys_clk_mult_q == clock_select_pkg::MULT_X4)
    else $error("system clock multiplier not four after code 000");

  periph_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && wr_cs && wstrb_q[0] && new_per == clock_select_pkg::SEL_X2
    && bus_ok |-> ##2 periph_clk_mult_q == clock_select_pkg::MULT_X2)
    else $error("peripheral clock multiplier not two after code 001");

  bus_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && wr_cs && wstrb_q[0] && new_bus == clock_select_pkg::SEL_X4
    && per_ok |-> ##2 bus_clk_mult_q == clock_select_pkg::MULT_X4)
    else $error("bus clock multiplier not four after code 000");

  stop_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && wr_ms && wstrb_q[0] && wdata_q[clock_select_pkg::TIMER_UNIT_STOP_BIT]
    |-> ##2 !module_run_q[clock_select_pkg::TIMER_UNIT_STOP_BIT])
    else $error("timer unit still running after stop write");

  dma_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 module_run_q[clock_select_pkg::EXT_DMA_STOP_BIT]
    |-> !$past(mstop_q[clock_select_pkg::EXT_DMA_STOP_BIT]))
    else $error("external dma running while its stop bit was set");

  all_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(all_clock_stop_q) |-> $past(cpu_sleep && all_off &&
      mstop_q[clock_select_pkg::ALL_CLOCK_STOP_ENABLE_BIT]))
    else $error("all-module stop without enable, sleep and modules off");

  reserved_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do && wr_cs && !sys_ok
    |=> $stable(clk_sel_q[clock_select_pkg::SYS_CLK_SEL_LSB +: 3]))
    else $error("reserved system clock code was taken");

endmodule : clock_select_and_module_stop

`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the clock select and module stop block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end

module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cpu_sleep, stop;
  logic [23:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  sys_m, per_m, bus_m;
  logic [14:0] run;
  logic [33:0] rq[$];
  int          err_count, check_count;

  clock_select_and_module_stop #(.ADDR_W(24)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_sleep(cpu_sleep),
    .sys_clk_mult_q(sys_m), .periph_clk_mult_q(per_m),
    .bus_clk_mult_q(bus_m), .module_run_q(run), .all_clock_stop_q(stop));

  ////////////////////////////////////////////////////////////////////////////
  // 25 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // bounded wait step, a hang is cut off here
  task automatic tick(inout int n);
    n++;
    if (n > 64)
    begin
      err_count++;
      $display("mismatch at %0t: handshake timeout", $time);
      wrap_up();
    end
  endtask : tick

  // ready is looked at mid-cycle so the taking edge is known without races
  task automatic axi_wr(input logic [23:0] a, input logic [15:0] d,
                        input logic [1:0] er);
    logic ta, tw, aw_d, w_d, hs;
    int   n;
    aw_d = 1'b0; w_d = 1'b0; hs = 1'b0; n = 0;
    awaddr <= a; wdata <= {16'h0000, d}; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin awvalid <= 1'b0; aw_d = 1'b1; end
      if (tw) begin wvalid <= 1'b0; w_d = 1'b1; end
      tick(n);
    end
    bready <= 1'b1;
    while (!hs)
    begin
      @(negedge aclk);
      hs = bvalid;
      `CHK(hs ? bresp : er, er)
      @(posedge aclk);
      tick(n);
    end
    bready <= 1'b0;
  endtask : axi_wr

  // the expected word goes to the queue, the monitor compares it
  task automatic axi_rd(input logic [23:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic ta, hs;
    int   n;
    ta = 1'b0; hs = 1'b0; n = 0;
    rq.push_back({er, d});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!hs)
    begin
      @(negedge aclk);
      ta = arvalid && arready; hs = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      tick(n);
    end
    rready <= 1'b0;
  endtask : axi_rd

  // settle three edges, then compare the clock control outputs
  task automatic chk_out(input logic [2:0] s, input logic [2:0] p,
                         input logic [2:0] b, input logic [14:0] r,
                         input logic st);
    repeat (3) @(negedge aclk);
    `CHK(sys_m, s)
    `CHK(per_m, p)
    `CHK(bus_m, b)
    `CHK(run, r)
    `CHK(stop, st)
    @(posedge aclk);
  endtask : chk_out

  function automatic logic [2:0] mult(input logic [2:0] c);
    return (c == 3'h0) ? clock_select_pkg::MULT_X4 : clock_select_pkg::MULT_X2;
  endfunction : mult

  ////////////////////////////////////////////////////////////////////////////
  // read data monitor: oldest note against each read answer
  // the note is popped once; the macro reads its arguments twice
  always @(negedge aclk)
  begin : rd_mon
    logic [33:0] exp_r;
    if (rvalid === 1'b1 && rready && rq.size() > 0)
    begin
      exp_r = rq.pop_front();
      `CHK({rresp, rdata}, exp_r)
    end
    else if (rvalid === 1'b1 && rready)
    begin
      err_count++;
      $display("mismatch at %0t: read answer with no note", $time);
    end
  end : rd_mon

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin : main_seq
    logic [15:0] ev, v;
    logic [2:0]  c;
    err_count = 0; check_count = 0;
    void'($urandom(32'h503e_1b9b));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_sleep} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_out(3'h4, 3'h2, 3'h4, 15'h7fff, 1'b0);
    axi_rd(24'hff_fdc4, 32'h0000_0010, 2'h0);
    axi_rd(24'hff_fdc8, 32'h0000_0000, 2'h0);
    // every select code in all three fields; reserved ones leave the field
    ev = 16'h0010;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i) ^ 3'h1;
      axi_wr(24'hff_fdc4, {5'h00, c, 1'b0, c, 1'b0, c}, 2'h0);
      if (c < 3'h2)
        ev = {5'h00, c, 1'b0, c, 1'b0, c};
      axi_rd(24'hff_fdc4, {16'h0000, ev}, 2'h0);
      chk_out(mult(ev[10:8]), mult(ev[6:4]), mult(ev[2:0]), 15'h7fff,
              1'b0);
    end
    axi_rd(24'hff_fdcc, 32'h0000_0002, 2'h0);
    // random stop patterns, awake cpu
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($urandom());
      v[15] = 1'b0;
      axi_wr(24'hff_fdc8, v, 2'h0);
      axi_rd(24'hff_fdc8, {16'h0000, v}, 2'h0);
      chk_out(3'h4, 3'h4, 3'h4, ~v[14:0], 1'b0);
    end
    // sleep with every implemented module stopped and the enable set
    axi_wr(24'hff_fdc8, 16'hc001, 2'h0);
    cpu_sleep <= 1'b1;
    chk_out(3'h4, 3'h4, 3'h4, 15'h0000, 1'b1);
    cpu_sleep <= 1'b0;
    chk_out(3'h4, 3'h4, 3'h4, 15'h3ffe, 1'b0);
    // one implemented module still running
    axi_wr(24'hff_fdc8, 16'h8001, 2'h0);
    cpu_sleep <= 1'b1;
    chk_out(3'h4, 3'h4, 3'h4, 15'h7ffe, 1'b0);
    // enable clear
    axi_wr(24'hff_fdc8, 16'h4001, 2'h0);
    chk_out(3'h4, 3'h4, 3'h4, 15'h3ffe, 1'b0);
    cpu_sleep <= 1'b0;
    // unmapped place: error answer, reads zero
    axi_wr(24'hff_fdd0, 16'hffff, 2'h2);
    axi_rd(24'hff_fdd0, 32'h0000_0000, 2'h2);
    repeat (4) @(posedge aclk);
    wrap_up();
  end : main_seq
endmodule : tb_top
`default_nettype wire
